// ### tsr_pkg.sv
// tsr_pkg: constants, types and register map of the temperature sensor serial register block
// assumes: shared by tsr_top and tsr_link; no other dependencies
//
// Function
// - converter runs on; link shows the last result captured while select was high
// - after select falls, 16 clocks shift out the pointed register, msb first
// - host may stop a response early by raising select
// - with select still low, the next 16 clocks shift in a command word
// - read command has bit 15 set, address in bits 4 and 3
// - read pointer holds until a full 16-clock response finishes
// - a full 16-bit response returns the pointer to temperature
// - a write command leaves the read pointer unchanged
// - after a read command the addressed word follows, after a write temperature
// - pointer 00 temperature, 01 configuration, 10 lower, 11 upper limit
// - configuration write fields sit at fixed bits with 010 in the low bits
// - write with low byte all ones enters power-down after current conversion
// - any later word with low byte not all ones leaves power-down; reset active
// - temperature word holds 13-bit value, bit 2 one, bits 1 and 0 floating
// - two's complement, 0.0625 degree steps, zero reads 0007
// - temperature reads zero until the first conversion completes
// - resolution 9 to 12 bits; unused low bits forced to zero
// - configuration resets with resolution 11, all else zero
// - mode 00 comparator, 01 interrupt, 10 interrupt-comparator
// - polarity 0 gives active-low alert, 1 active-high
// - fault count 00/01/10/11 needs 1/2/4/6 consecutive faults
// - comparator alert sets at or above upper, clears below lower
// - interrupt alert clears on a full 16-clock response or power-down, then rearms opposite limit
// - upper limit resets to 80 degrees, lower limit to 75 degrees
package tsr_pkg;

  // ------------------------------------------------------------------
  // register pointers and word layout
  // ------------------------------------------------------------------
  localparam logic [1:0]  TSR_PTR_TEMP     = 2'h0;
  localparam logic [1:0]  TSR_PTR_CONFIG   = 2'h1;
  localparam logic [1:0]  TSR_PTR_LOWER    = 2'h2;
  localparam logic [1:0]  TSR_PTR_UPPER    = 2'h3;
  localparam int          TSR_WORD_BITS    = 16;
  localparam int          TSR_CMD_READ_BIT = 15;
  localparam int          TSR_PTR_LSB      = 3;
  localparam logic [2:0]  TSR_TAG_CONFIG   = 3'h2;
  localparam logic [2:0]  TSR_TAG_LOWER    = 3'h4;
  localparam logic [2:0]  TSR_TAG_UPPER    = 3'h6;
  localparam logic [7:0]  TSR_SHUTDOWN_LOW = 8'hff;
  localparam logic [2:0]  TSR_TEMP_TAIL    = 3'h7;
  localparam logic [3:0]  TSR_CFG_TOP_ZERO = 4'h0;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [12:0] TSR_TEMP_RESET   = 13'h0000;
  localparam logic [12:0] TSR_UPPER_RESET  = 13'h0500;  // 80 degrees
  localparam logic [12:0] TSR_LOWER_RESET  = 13'h04b0;  // 75 degrees
  localparam logic [1:0]  TSR_RES_RESET    = 2'h3;

  // ------------------------------------------------------------------
  // configuration fields
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    TSR_MODE_COMP    = 2'b00,
    TSR_MODE_INT     = 2'b01,
    TSR_MODE_INTCOMP = 2'b10,
    TSR_MODE_UNDEF   = 2'b11
  } tsr_mode_t;

  typedef struct packed {
    logic [1:0] conversion_delay_sel;
    logic [1:0] resolution_sel;
    logic [1:0] fault_count_sel;
    logic       alert_polarity;
    tsr_mode_t  thermostat_mode_sel;
  } tsr_cfg_t;

  localparam tsr_cfg_t TSR_CFG_RESET = '{conversion_delay_sel: 2'h0, resolution_sel: TSR_RES_RESET,
                                         fault_count_sel: 2'h0, alert_polarity: 1'b0,
                                         thermostat_mode_sel: TSR_MODE_COMP};

  // command word handed from the link domain
  typedef struct packed {
    logic [15:0] word;
  } tsr_cmd_t;

endpackage

// ### tsr_link.sv
// tsr_link: serial shifter on the link clock; shifts response, captures command words
// assumes: link clock only toggles while select is low; select raised resets framing
`timescale 1ns/10ps
module tsr_link
  import tsr_pkg::*;
(
  // reset, only to start the handover toggles at a known level
  input  wire logic        resetn_in,
  // link pins
  input  wire logic        sck_in,
  input  wire logic        cs_n_in,
  input  wire logic        sdi_in,
  output logic             sdo_out,
  output logic             sdo_oe_out,
  // response word source (held stable by system domain)
  input  wire logic [15:0] resp_word_in,
  // toggles towards system domain
  output logic             cmd_tgl_out,
  output tsr_cmd_t         cmd_out,
  output logic             done_tgl_out
);

  // ------------------------------------------------------------------
  // framing counter on rising edges; select high clears the frame
  // ------------------------------------------------------------------
  logic [4:0]  bit_cnt;
  logic        in_cmd;
  logic [15:0] shift_in;
  logic [3:0]  out_idx;
  logic        resp_phase;

  wire last_bit   = (bit_cnt == 5'd15);
  wire [15:0] next_shift_in = {shift_in[14:0], sdi_in};

  // count bits, alternate response and command halves
  always_ff @(posedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      bit_cnt <= 5'd0;
      in_cmd  <= 1'b0;
    end else begin
      bit_cnt <= last_bit ? 5'd0 : bit_cnt + 5'd1;
      if (last_bit)
        in_cmd <= ~in_cmd;
    end
  end

  // sample command bits on the rising edge
  always_ff @(posedge sck_in) begin
    shift_in <= next_shift_in;
  end

  // completed command word and full response handed over by toggles
  // toggles start equal to the system side's seen flops, so no false event
  always_ff @(posedge sck_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cmd_tgl_out  <= 1'b0;
      cmd_out      <= '{word: 16'h0000};
      done_tgl_out <= 1'b0;
    end else begin
      if (last_bit && in_cmd) begin
        cmd_out     <= '{word: next_shift_in};
        cmd_tgl_out <= ~cmd_tgl_out;
      end
      if (last_bit && !in_cmd)
        done_tgl_out <= ~done_tgl_out;
    end
  end

  // response bit index, advanced on falling edges
  always_ff @(negedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      out_idx    <= 4'hf;
      resp_phase <= 1'b1;
    end else begin
      out_idx    <= out_idx - 4'd1;
      if (out_idx == 4'd0)
        resp_phase <= ~resp_phase;
    end
  end

  // sign bit first; low two temperature bits float
  wire float_bit = (resp_word_in[2:0] == TSR_TEMP_TAIL) && (out_idx < 4'd2);
  assign sdo_out    = resp_word_in[out_idx];
  assign sdo_oe_out = !cs_n_in && resp_phase && !float_bit;

endmodule

// ### tsr_top.sv
// tsr_top: temperature sensor register block with serial link and alert logic
// assumes: converter result arrives as a strobe on clk_sys_in; link clock separate
`timescale 1ns/10ps
module tsr_top
  import tsr_pkg::*;
(
  // system
  input  wire logic        clk_sys_in,
  input  wire logic        resetn_in,
  // link pins
  input  wire logic        sck_in,
  input  wire logic        cs_n_in,
  input  wire logic        sdi_in,
  output logic             sdo_out,
  output logic             sdo_oe_out,
  // converter side
  input  wire logic        conv_done_in,
  input  wire logic [12:0] conv_value_in,
  output logic             power_down_mode_out,
  output logic [1:0]       conversion_delay_sel_out,
  output logic [1:0]       resolution_sel_out,
  // alert pin, open drain
  output logic             alert_out,
  output logic             alert_oe_out
);

  // ------------------------------------------------------------------
  // register state
  // ------------------------------------------------------------------
  logic [12:0] temperature_result;
  logic [12:0] lower_limit;
  logic [12:0] upper_limit;
  tsr_cfg_t    operating_config;
  logic [1:0]  read_pointer_bits;
  logic        power_down_mode;
  logic        pd_pending;
  logic        alert_active;
  logic        int_arm_low;
  logic [2:0]  fault_hi_cnt;
  logic [2:0]  fault_lo_cnt;
  logic        intcomp_wait;
  logic [15:0] resp_word;

  // ------------------------------------------------------------------
  // link domain
  // ------------------------------------------------------------------
  logic     cmd_tgl;
  logic     done_tgl;
  tsr_cmd_t cmd_link;

  tsr_link u_link (
    .resetn_in    (resetn_in),
    .sck_in       (sck_in),
    .cs_n_in      (cs_n_in),
    .sdi_in       (sdi_in),
    .sdo_out      (sdo_out),
    .sdo_oe_out   (sdo_oe_out),
    .resp_word_in (resp_word),
    .cmd_tgl_out  (cmd_tgl),
    .cmd_out      (cmd_link),
    .done_tgl_out (done_tgl)
  );

  // ------------------------------------------------------------------
  // crossings: two flops per toggle, edge on the second stage
  // ------------------------------------------------------------------
  logic [1:0] cmd_sync;
  logic [1:0] done_sync;
  logic       cmd_seen;
  logic       done_seen;

  // synchronise event toggles
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cmd_sync  <= 2'b00;
      done_sync <= 2'b00;
      cmd_seen  <= 1'b0;
      done_seen <= 1'b0;
    end else begin
      cmd_sync  <= {cmd_sync[0], cmd_tgl};
      done_sync <= {done_sync[0], done_tgl};
      cmd_seen  <= cmd_sync[1];
      done_seen <= done_sync[1];
    end
  end

  wire cmd_evt  = cmd_sync[1] ^ cmd_seen;
  wire done_evt = done_sync[1] ^ done_seen;

  // command word is stable long before its toggle arrives
  wire [15:0] cmd_word = cmd_link.word;

  // ------------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------------
  wire       is_read    = cmd_evt && cmd_word[TSR_CMD_READ_BIT];
  wire       is_write   = cmd_evt && !cmd_word[TSR_CMD_READ_BIT];
  wire [1:0] cmd_ptr    = cmd_word[TSR_PTR_LSB +: 2];
  wire       low_ones   = (cmd_word[7:0] == TSR_SHUTDOWN_LOW);
  wire       wr_config  = is_write && (cmd_word[2:0] == TSR_TAG_CONFIG)
                          && (cmd_word[15:12] == TSR_CFG_TOP_ZERO);
  wire       wr_lower   = is_write && (cmd_word[2:0] == TSR_TAG_LOWER) && !low_ones;
  wire       wr_upper   = is_write && (cmd_word[2:0] == TSR_TAG_UPPER) && !low_ones;
  wire       go_down    = is_write && low_ones;
  wire       wake       = cmd_evt && !low_ones;

  // ------------------------------------------------------------------
  // read pointer: read command loads, full response clears, write keeps
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in)
      read_pointer_bits <= TSR_PTR_TEMP;
    else if (is_read)
      read_pointer_bits <= cmd_ptr;
    else if (done_evt)
      read_pointer_bits <= TSR_PTR_TEMP;
  end                                                // write leaves it

  // ------------------------------------------------------------------
  // writable registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      operating_config <= TSR_CFG_RESET;
      lower_limit      <= TSR_LOWER_RESET;
      upper_limit      <= TSR_UPPER_RESET;
    end else begin
      if (wr_config)
        operating_config <= tsr_cfg_t'(cmd_word[11:3]);
      if (wr_lower)
        lower_limit <= cmd_word[15:3];
      if (wr_upper)
        upper_limit <= cmd_word[15:3];
    end
  end

  // ------------------------------------------------------------------
  // temperature capture with resolution masking
  // ------------------------------------------------------------------
  function automatic logic [12:0] tsr_res_mask(input logic [1:0] res);
    tsr_res_mask = 13'h1fff << (2'd3 - res);
  endfunction

  function automatic logic [2:0] tsr_fault_need(input logic [1:0] sel);
    unique case (sel)
      2'b00: tsr_fault_need = 3'd1;
      2'b01: tsr_fault_need = 3'd2;
      2'b10: tsr_fault_need = 3'd4;
      2'b11: tsr_fault_need = 3'd6;
    endcase
  endfunction

  // converter keeps running; frames never stall it
  wire        conv_take = conv_done_in && !power_down_mode;
  wire [12:0] next_temp = conv_value_in & tsr_res_mask(operating_config.resolution_sel);

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in)
      temperature_result <= TSR_TEMP_RESET;
    else if (conv_take)
      temperature_result <= next_temp;
  end

  // ------------------------------------------------------------------
  // power-down: entered at end of current conversion, left on wake word
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      power_down_mode <= 1'b0;
      pd_pending      <= 1'b0;
    end else begin
      if (go_down)
        pd_pending <= 1'b1;
      else if (wake || conv_take)
        pd_pending <= 1'b0;
      if (wake)
        power_down_mode <= 1'b0;
      else if (pd_pending && conv_done_in)
        power_down_mode <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // response word selection, held for the link domain
  // ------------------------------------------------------------------
  wire [15:0] cfg_word = {TSR_CFG_TOP_ZERO, operating_config, TSR_TAG_CONFIG};
  wire signed [12:0] t_s  = next_temp;  // judge the conversion just completed
  wire signed [12:0] hi_s = upper_limit;
  wire signed [12:0] lo_s = lower_limit;

  logic [15:0] next_resp;
  always_comb begin
    unique case (read_pointer_bits)
      TSR_PTR_TEMP:   next_resp = {temperature_result, TSR_TEMP_TAIL};
      TSR_PTR_CONFIG: next_resp = cfg_word;
      TSR_PTR_LOWER:  next_resp = {lower_limit, TSR_TAG_LOWER};
      TSR_PTR_UPPER:  next_resp = {upper_limit, TSR_TAG_UPPER};
    endcase
  end

  // refresh only while select is high so a frame sees a stable word
  logic [1:0] cs_sync;
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cs_sync   <= 2'b11;
      resp_word <= {TSR_TEMP_RESET, TSR_TEMP_TAIL};
    end else begin
      cs_sync <= {cs_sync[0], cs_n_in};
      if (cs_sync[1])
        resp_word <= next_resp;
    end
  end

  // ------------------------------------------------------------------
  // fault queue and thermostat alert
  // ------------------------------------------------------------------
  wire [2:0]  need    = tsr_fault_need(operating_config.fault_count_sel);
  wire        is_hi   = t_s >= hi_s;
  wire        is_lo   = t_s < lo_s;
  wire        hi_full = conv_take && is_hi && (fault_hi_cnt + 3'd1 >= need);
  wire        lo_full = conv_take && is_lo && (fault_lo_cnt + 3'd1 >= need);
  wire        any_rd  = done_evt;
  tsr_mode_t  mode;
  assign mode = operating_config.thermostat_mode_sel;

  // consecutive fault counters
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fault_hi_cnt <= 3'd0;
      fault_lo_cnt <= 3'd0;
    end else if (conv_take) begin
      fault_hi_cnt <= is_hi ? (hi_full ? need : fault_hi_cnt + 3'd1) : 3'd0;
      fault_lo_cnt <= is_lo ? (lo_full ? need : fault_lo_cnt + 3'd1) : 3'd0;
    end
  end

  // alert state per thermostat mode
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      alert_active <= 1'b0;
      int_arm_low  <= 1'b0;
      intcomp_wait <= 1'b0;
    end else begin
      unique case (mode)
        TSR_MODE_COMP: begin
          if (hi_full)
            alert_active <= 1'b1;
          else if (lo_full)
            alert_active <= 1'b0;
        end
        TSR_MODE_INT: begin
          if ((!int_arm_low && hi_full) || (int_arm_low && lo_full)) begin
            alert_active <= 1'b1;
            int_arm_low  <= ~int_arm_low;
          end else if (any_rd || power_down_mode)
            alert_active <= 1'b0;
        end
        TSR_MODE_INTCOMP: begin
          if (hi_full) begin
            alert_active <= 1'b1;
            intcomp_wait <= 1'b0;
          end else if (lo_full)
            intcomp_wait <= 1'b1;
          else if (intcomp_wait && (any_rd || cmd_evt)) begin
            alert_active <= 1'b0;
            intcomp_wait <= 1'b0;
          end
        end
        default: alert_active <= alert_active;       // undefined mode holds
      endcase
    end
  end

  // polarity: 0 drives low while active, 1 drives low while inactive and releases while active
  wire alert_level = operating_config.alert_polarity ? alert_active : ~alert_active;
  assign alert_out    = 1'b0;
  assign alert_oe_out = ~alert_level;                 // open drain: pull-up gives high

  // ------------------------------------------------------------------
  // converter controls
  // ------------------------------------------------------------------
  assign power_down_mode_out      = power_down_mode;
  assign conversion_delay_sel_out = operating_config.conversion_delay_sel;
  assign resolution_sel_out       = operating_config.resolution_sel;

endmodule

// ### tsr_chk.sv
// tsr_chk: pin-level checks of the sensor register block
// assumes: bound to tsr_top; link clock runs only while select is low
`timescale 1ns/10ps
module tsr_chk
  import tsr_pkg::*;
(
  // system and converter
  input wire logic        clk_sys_in,
  input wire logic        resetn_in,
  input wire logic        conv_done_in,
  input wire logic [12:0] conv_value_in,
  // link
  input wire logic        sck_in,
  input wire logic        cs_n_in,
  input wire logic        sdi_in,
  input wire logic        sdo_out,
  input wire logic        sdo_oe_out,
  // status and alert
  input wire logic        power_down_mode_out,
  input wire logic [1:0]  conversion_delay_sel_out,
  input wire logic [1:0]  resolution_sel_out,
  input wire logic        alert_out,
  input wire logic        alert_oe_out
);
  logic [4:0] bit_cnt;
  // link clocks seen in this frame, cleared while select is high
  always_ff @(posedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      bit_cnt <= 5'h00;
    end else begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  sequence s_quiet;
    (cs_n_in && !conv_done_in) [*8];
  endsequence
  property p_rst_vals;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      $rose(resetn_in) |-> !power_down_mode_out && resolution_sel_out == 2'h3 && conversion_delay_sel_out == 2'h0;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset value wrong");
  property p_rst_alert;
    @(posedge clk_sys_in) disable iff (!resetn_in) $rose(resetn_in) |-> !alert_oe_out;
  endproperty
  a_rst_alert: assert property (p_rst_alert) else $error("alert active after reset");
  property p_alert_od;
    @(posedge clk_sys_in) disable iff (!resetn_in) alert_out == 1'h0;
  endproperty
  a_alert_od: assert property (p_alert_od) else $error("alert pin driven high");
  property p_cs_release;
    @(posedge clk_sys_in) disable iff (!resetn_in) cs_n_in [*2] |-> !sdo_oe_out;
  endproperty
  a_cs_release: assert property (p_cs_release) else $error("data line held after select");
  property p_resp_drive;
    @(posedge sck_in) disable iff (cs_n_in || !resetn_in) bit_cnt < 5'h0e |-> sdo_oe_out;
  endproperty
  a_resp_drive: assert property (p_resp_drive) else $error("response bit not driven");
  property p_cmd_release;
    @(posedge sck_in) disable iff (cs_n_in || !resetn_in) bit_cnt[4] |-> !sdo_oe_out;
  endproperty
  a_cmd_release: assert property (p_cmd_release) else $error("driving in command half");
  property p_quiet_cfg;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      s_quiet |=> $stable(power_down_mode_out) && $stable(resolution_sel_out) && $stable(conversion_delay_sel_out);
  endproperty
  a_quiet_cfg: assert property (p_quiet_cfg) else $error("setting moved while idle");
  property p_quiet_alert;
    @(posedge clk_sys_in) disable iff (!resetn_in) s_quiet |=> $stable(alert_oe_out);
  endproperty
  a_quiet_alert: assert property (p_quiet_alert) else $error("alert moved while idle");
endmodule

// ### tsr_host.sv
// tsr_host: host model driving select, link clock and the shared data line
// assumes: link clock idles low and runs only inside frames
`timescale 1ns/10ps
module tsr_host (
  // link pins
  output logic      sck_out,
  output logic      cs_n_out,
  output logic      sdi_out,
  // device drive
  input  wire logic sdo_in,
  input  wire logic sdo_oe_in
);
  logic drv;
  logic hd;
  // wire level; an undriven line shows the inverse of the last host bit
  assign sdi_out = sdo_oe_in ? sdo_in : (drv ? hd : ~hd);
  initial begin
    sck_out = 1'h0;
    cs_n_out = 1'h1;
    drv = 1'h0;
    hd = 1'h0;
  end
  // ------------------------------------------------------------
  // one frame: n response bits, then an optional command word
  // ------------------------------------------------------------
  task automatic xfer(input logic [15:0] cmd, input int n, input bit c,
                      output logic [15:0] rsp, output logic [15:0] oe);
    rsp = 16'h0000;
    oe = 16'h0000;
    cs_n_out = 1'h0;
    #20;
    for (int i = 0; i < n; i++) begin // may stop early
      #7.5;
      rsp[15-i] = sdi_out; // settled bit, taken just before the rising edge
      oe[15-i] = sdo_oe_in;
      sck_out = 1'h1;
      #7.5 sck_out = 1'h0;
    end
    if (c) begin // command follows a whole response
      drv = 1'h1;
      for (int i = 0; i < 16; i++) begin
        hd = cmd[15-i]; // change after falling edge
        #7.5 sck_out = 1'h1;
        #7.5 sck_out = 1'h0;
      end
    end
    #10 cs_n_out = 1'h1;
    drv = 1'h0;
    #200;
  endtask
endmodule

// ### tb.sv
// tb: drives the sensor register block through the host model and a converter stub
// assumes: tsr_pkg, tsr_top, tsr_host and tsr_chk compiled first
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  $display("mismatch %s exp %h got %h", nm, e, g); n_errors++; end end
module tb;
  logic        clk;
  logic        rst_n;
  logic        cdone;
  logic [12:0] cval;
  logic        sck;
  logic        cs_n;
  logic        sdi;
  logic        sdo;
  logic        sdo_oe;
  logic        pd;
  logic [1:0]  dly;
  logic [1:0]  res;
  logic        al;
  logic        al_oe;
  logic [15:0] rsp;
  logic [15:0] oe;
  int          n_errors = 0;
  int          n_checks = 0;
  int          nf [4] = '{1, 2, 4, 6};
  logic [15:0] rv [4] = '{16'h0000, 16'h0302, 16'h2584, 16'h2806};
  // clock
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  tsr_top i_dut (.clk_sys_in(clk), .resetn_in(rst_n), .sck_in(sck), .cs_n_in(cs_n), .sdi_in(sdi),
    .sdo_out(sdo), .sdo_oe_out(sdo_oe), .conv_done_in(cdone), .conv_value_in(cval),
    .power_down_mode_out(pd), .conversion_delay_sel_out(dly), .resolution_sel_out(res),
    .alert_out(al), .alert_oe_out(al_oe));
  tsr_host i_host (.sck_out(sck), .cs_n_out(cs_n), .sdi_out(sdi), .sdo_in(sdo), .sdo_oe_in(sdo_oe));
  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  task automatic fr(input logic [15:0] w, input int n, input bit c);
    i_host.xfer(w, n, c, rsp, oe);
  endtask
  task automatic wr(input logic [15:0] w);
    fr(w, 16, 1);
  endtask
  task automatic rdp(input logic [1:0] p);
    fr({11'h400, p, 3'h0}, 16, 1);
    fr(16'h0000, 16, 0);
  endtask
  // converter strobe, then let the alert path settle
  task automatic conv(input logic [12:0] v);
    @(posedge clk);
    cdone <= 1'h1;
    cval <= v;
    @(posedge clk);
    cdone <= 1'h0;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic complete_run;
    if (n_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #300000;
    n_errors++;
    complete_run();
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'h0;
    cdone = 1'h0;
    cval = 13'h0000;
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    repeat (6) @(posedge clk);
    `CHK("reset", {1'h0, 2'h3, 2'h0, 1'h0}, {pd, res, dly, al_oe})
    fr(16'h0000, 16, 0);
    `CHK("temp0", {14'h0001, 16'hfffc}, {rsp[15:2], oe})
    for (int p = 1; p < 4; p++) begin
      rdp(2'(p));
      `CHK("reg_rst", {rv[p], 16'hffff}, {rsp, oe})
      fr(16'h0000, 16, 0);
      `CHK("ptr_back", 14'h0001, rsp[15:2])
    end
    fr(16'h8018, 16, 1);
    fr(16'h0000, 5, 0);
    `CHK("part", 5'h05, rsp[15:11])
    fr(16'h0000, 16, 0);
    `CHK("held", 16'h2806, rsp)
    for (int r = 0; r < 4; r++) begin
      wr({4'h0, 2'(r), 2'(r), 8'h02});
      `CHK("cfg_out", {2'(r), 2'(r)}, {dly, res})
      conv(13'h0fff);
      fr(16'h0000, 16, 0);
      `CHK("res_t", 13'h0fff & (13'h1fff << (3 - r)), rsp[15:3])
    end
    conv(13'h1fff);
    fr(16'h0000, 16, 0);
    `CHK("neg", 14'h3fff, rsp[15:2])
    wr({13'h0100, 3'h6});
    wr({13'h00f0, 3'h4});
    rdp(2'h3);
    `CHK("upper", 16'h0806, rsp)
    rdp(2'h2);
    `CHK("lower", 16'h0784, rsp)
    for (int f = 0; f < 4; f++) begin
      wr({8'h03, 2'(f), 6'h02});
      for (int k = 1; k <= nf[f]; k++) begin
        conv(13'h0100);
        `CHK("al_up", k == nf[f], al_oe)
      end
      for (int k = 1; k <= nf[f]; k++) begin
        conv(13'h0010);
        `CHK("al_dn", k != nf[f], al_oe)
      end
    end
    wr(16'h0322);
    `CHK("pol_idle", 1'h1, al_oe)
    conv(13'h0100);
    `CHK("pol_act", 1'h0, al_oe)
    conv(13'h0010);
    wr(16'h030a);
    conv(13'h0100);
    `CHK("int_set", 1'h1, al_oe)
    fr(16'h0000, 16, 0);
    `CHK("int_clr", 1'h0, al_oe)
    conv(13'h0100);
    `CHK("int_arm", 1'h0, al_oe)
    conv(13'h0010);
    `CHK("int_low", 1'h1, al_oe)
    conv(13'h0020);
    wr(16'h00ff);
    conv(13'h0020);
    `CHK("sd_on", {1'h1, 1'h0}, {pd, al_oe})
    conv(13'h0040);
    fr(16'h0000, 16, 0);
    `CHK("sd_hold", 13'h0020, rsp[15:3])
    wr(16'h0000);
    `CHK("sd_off", 1'h0, pd)
    conv(13'h0040);
    fr(16'h0000, 16, 0);
    `CHK("sd_run", 13'h0040, rsp[15:3])
    wr(16'h0312);
    conv(13'h0100);
    `CHK("ic_set", 1'h1, al_oe)
    conv(13'h0010);
    `CHK("ic_hold", 1'h1, al_oe)
    fr(16'h0000, 16, 0);
    `CHK("ic_clr", 1'h0, al_oe)
    complete_run();
  end
endmodule
bind tsr_top tsr_chk i_chk (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .conv_done_in(conv_done_in),
  .conv_value_in(conv_value_in), .sck_in(sck_in), .cs_n_in(cs_n_in), .sdi_in(sdi_in), .sdo_out(sdo_out),
  .sdo_oe_out(sdo_oe_out), .power_down_mode_out(power_down_mode_out),
  .conversion_delay_sel_out(conversion_delay_sel_out), .resolution_sel_out(resolution_sel_out),
  .alert_out(alert_out), .alert_oe_out(alert_oe_out));
